// ---- hdl/artd_core.sv ----
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
// Notes on behaviour
// - 0x24D and 0x24E load acc from timer control three and four.
// - 0x052 copies column pointer into acc, pointer unchanged.
// - 0x053 puts bank pointer in acc bits 1:0, bits 3:2 zero.
// - 0x00E copies acc into the secondary working register.
// - Two instructions copy acc into aux register one and two.
// - 0x029 copies acc bits 2:0 to jump address; bit 3 ignored.
// - 0x01A writes working reg to ext 7:4 and acc to ext 3:0.
// - 0x217 to irq control; 0x03F and 0x03E to irq enables.
// - Acc copies to three wakeup regs; second 0x214, third 0x215.
// - 0x20A..0x20C copy acc into display control one to three.
// - 0x20D writes acc to display timer count and reload together.
// - 0x2B0..0x2BF store acc at pointer, then column ^= immediate.
// - 0x216 copies acc into clock mode register.
// - 0x2AA copies only acc bit 0 into port assign bit 0.
// - 0x235 loads prescale count and reload from working reg, acc.
// - 0x22D and 0x22E copy acc into pull-up control regs.
// - 0x23F writes working reg and acc into timer 1 reload.
// - 0x209 copies acc into clock source register.
// - 0x20E and 0x20F copy acc into timer control one and two.
// - 0x01F copies row pointer into acc.
module artd_core
  import artd_pkg::*;
#(
  parameter int RAM_WORDS = ARTD_RAM_WORDS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic carry_flag,
  output logic skip_next
);

  // ---------------------------------------------------------------
  // Bus capture
  // ---------------------------------------------------------------
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;
  logic [3:0] acc_reg, work_reg, col_reg, row_reg;
  logic [1:0] bank_reg;
  logic [3:0] tmr_ctl_one, tmr_ctl_two, tmr_ctl_three, tmr_ctl_four;
  logic [3:0] aux_reg_one, aux_reg_two;
  logic [2:0] jump_addr_bits;
  logic [7:0] ext_reg, tmr1_reload, prescale_reload, prescale_count;
  logic [3:0] port_outstruct_zero, port_outstruct_one, port_outstruct_two;
  logic [3:0] irq_ctl_first, irq_enable_one, irq_enable_two;
  logic [3:0] wake_ctl_zero, wake_ctl_one, wake_ctl_two;
  logic [3:0] disp_ctl_one, disp_ctl_two, disp_ctl_three;
  logic [3:0] disp_timer_count, disp_timer_reload;
  logic [3:0] clk_mode_reg, clk_source_reg;
  logic tmr_port_assign;
  logic [3:0] ram_mem [RAM_WORDS];
  logic [31:0] insn_cnt_reg;
  logic exec;
  logic [9:0] op;
  logic acc_wr;
  logic [3:0] acc_next;

  // Address phase taken only while the bus is ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      rd_pend_reg <= hsel && htrans[1] && !hwrite;
      addr_reg <= haddr[7:0];
    end
  end

  // Zero wait states: every access finishes in its data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // An instruction is executed by a write to the instruction word
  assign exec = wr_pend_reg && (addr_reg == ARTD_OFF_INSN);
  assign op = hwdata[9:0];

  // Never touches carry and never asks for a skip
  assign carry_flag = 1'b0;
  assign skip_next = 1'b0;

  // ---------------------------------------------------------------
  // Accumulator loads
  // ---------------------------------------------------------------
  always_comb begin
    acc_wr = 1'b0;
    acc_next = acc_reg;
    if (exec) begin
      acc_wr = 1'b1;
      case (op)
        OP_TAW3: acc_next = tmr_ctl_three;
        OP_TAW4: acc_next = tmr_ctl_four;
        OP_TAX: acc_next = col_reg;
        OP_TAZ: acc_next = {2'b00, bank_reg};
        OP_TAY: acc_next = row_reg;
        default: acc_wr = 1'b0;
      endcase
    end
  end

  // Pointers, accumulator and working register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= ARTD_RST_NIB;
      work_reg <= ARTD_RST_NIB;
      col_reg <= ARTD_RST_NIB;
      row_reg <= ARTD_RST_NIB;
      bank_reg <= 2'b00;
    end else if (wr_pend_reg && addr_reg == ARTD_OFF_ACC) begin
      acc_reg <= hwdata[3:0];
    end else if (wr_pend_reg && addr_reg == ARTD_OFF_WORK) begin
      work_reg <= hwdata[3:0];
    end else if (wr_pend_reg && addr_reg == ARTD_OFF_PTR) begin
      col_reg <= hwdata[3:0];
      row_reg <= hwdata[7:4];
      bank_reg <= hwdata[9:8];
    end else if (acc_wr) begin
      acc_reg <= acc_next;
    end else if (exec && op == OP_TBA) begin
      work_reg <= acc_reg;
    end else if (exec && op[9:4] == OP_STORE_HI) begin
      col_reg <= col_reg ^ op[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Peripheral destinations; acc updates on the same edge, reads take old acc
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_ctl_one <= ARTD_RST_NIB;
      tmr_ctl_two <= ARTD_RST_NIB;
      tmr_ctl_three <= ARTD_RST_NIB;
      tmr_ctl_four <= ARTD_RST_NIB;
      aux_reg_one <= ARTD_RST_NIB;
      aux_reg_two <= ARTD_RST_NIB;
      jump_addr_bits <= 3'b000;
      ext_reg <= 8'h00;
      tmr1_reload <= 8'h00;
      prescale_reload <= 8'h00;
      prescale_count <= 8'h00;
      port_outstruct_zero <= ARTD_RST_NIB;
      port_outstruct_one <= ARTD_RST_NIB;
      port_outstruct_two <= ARTD_RST_NIB;
      irq_ctl_first <= ARTD_RST_NIB;
      irq_enable_one <= ARTD_RST_NIB;
      irq_enable_two <= ARTD_RST_NIB;
      wake_ctl_zero <= ARTD_RST_NIB;
      wake_ctl_one <= ARTD_RST_NIB;
      wake_ctl_two <= ARTD_RST_NIB;
      disp_ctl_one <= ARTD_RST_NIB;
      disp_ctl_two <= ARTD_RST_NIB;
      disp_ctl_three <= ARTD_RST_NIB;
      disp_timer_count <= ARTD_RST_NIB;
      disp_timer_reload <= ARTD_RST_NIB;
      clk_mode_reg <= ARTD_RST_NIB;
      clk_source_reg <= ARTD_RST_NIB;
      tmr_port_assign <= 1'b0;
    end else if (wr_pend_reg && addr_reg == ARTD_OFF_TMR) begin
      // Timer side stand-in, so the timer loads see live values
      tmr_ctl_three <= hwdata[11:8];
      tmr_ctl_four <= hwdata[15:12];
    end else if (exec) begin
      case (op)
        OP_TW1: tmr_ctl_one <= acc_reg;
        OP_TW2: tmr_ctl_two <= acc_reg;
        OP_TC1A: aux_reg_one <= acc_reg;
        OP_TC2A: aux_reg_two <= acc_reg;
        OP_TDA: jump_addr_bits <= acc_reg[2:0];
        OP_EXT_PAIR: ext_reg <= {work_reg, acc_reg};
        OP_TFR0: port_outstruct_zero <= acc_reg;
        OP_TFR1: port_outstruct_one <= acc_reg;
        OP_TFR2: port_outstruct_two <= acc_reg;
        OP_TI1: irq_ctl_first <= acc_reg;
        OP_TV1: irq_enable_one <= acc_reg;
        OP_TV2: irq_enable_two <= acc_reg;
        OP_TK0: wake_ctl_zero <= acc_reg;
        OP_TK1: wake_ctl_one <= acc_reg;
        OP_TK2: wake_ctl_two <= acc_reg;
        OP_TL1: disp_ctl_one <= acc_reg;
        OP_TL2: disp_ctl_two <= acc_reg;
        OP_TL3: disp_ctl_three <= acc_reg;
        OP_TLC: begin
          disp_timer_count <= acc_reg;
          disp_timer_reload <= acc_reg;
        end
        OP_TMR: clk_mode_reg <= acc_reg;
        OP_TPA: tmr_port_assign <= acc_reg[0];
        OP_PRE_PAIR: begin
          prescale_count <= {work_reg, acc_reg};
          prescale_reload <= {work_reg, acc_reg};
        end
        OP_TR1: tmr1_reload <= {work_reg, acc_reg};
        OP_TRG: clk_source_reg <= acc_reg;
        default: ;
      endcase
    end
  end

  // Pull-up registers kept apart; their opcodes share no destination
  logic [3:0] pullup_ctl_zero, pullup_ctl_one;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pullup_ctl_zero <= ARTD_RST_NIB;
      pullup_ctl_one <= ARTD_RST_NIB;
    end else if (exec && op == OP_TPU0) begin
      pullup_ctl_zero <= acc_reg;
    end else if (exec && op == OP_TPU1) begin
      pullup_ctl_one <= acc_reg;
    end
  end

  // Data RAM; small window, addressed by the column pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < RAM_WORDS; i++) begin
        ram_mem[i] <= ARTD_RST_NIB;
      end
    end else if (exec && op[9:4] == OP_STORE_HI) begin
      ram_mem[col_reg] <= acc_reg;
    end
  end

  // Count of executed instructions, for software visibility
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      insn_cnt_reg <= 32'h00000000;
    end else if (exec) begin
      insn_cnt_reg <= insn_cnt_reg + 32'h00000001;
    end
  end

  // ---------------------------------------------------------------
  // Read mux; unmapped offsets read zero
  // ---------------------------------------------------------------
  always_comb begin
    hrdata = 32'h00000000;
    if (rd_pend_reg) begin
      case (addr_reg)
        ARTD_OFF_ACC: hrdata = {28'h0, acc_reg};
        ARTD_OFF_WORK: hrdata = {28'h0, work_reg};
        ARTD_OFF_PTR: hrdata = {22'h0, bank_reg, row_reg, col_reg};
        ARTD_OFF_TMR: hrdata = {16'h0, tmr_ctl_four, tmr_ctl_three,
                                tmr_ctl_two, tmr_ctl_one};
        ARTD_OFF_PORT: hrdata = {12'h0, pullup_ctl_one, pullup_ctl_zero,
                                 port_outstruct_two, port_outstruct_one,
                                 port_outstruct_zero};
        ARTD_OFF_IRQ: hrdata = {8'h0, wake_ctl_two, wake_ctl_one,
                                wake_ctl_zero, irq_enable_two,
                                irq_enable_one, irq_ctl_first};
        ARTD_OFF_DISP: hrdata = {12'h0, disp_timer_reload,
                                 disp_timer_count, disp_ctl_three,
                                 disp_ctl_two, disp_ctl_one};
        ARTD_OFF_CLK: hrdata = {20'h0, 3'b000, tmr_port_assign,
                                clk_source_reg, clk_mode_reg};
        ARTD_OFF_PRE: hrdata = {prescale_count, prescale_reload,
                                tmr1_reload, ext_reg};
        ARTD_OFF_RAM: hrdata = {28'h0, ram_mem[col_reg]};
        ARTD_OFF_STAT: hrdata = insn_cnt_reg;
        ARTD_OFF_AUX: hrdata = {21'h0, jump_addr_bits, aux_reg_two,
                                aux_reg_one};
        default: hrdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_exec(logic [9:0] c);
    exec && op == c;
  endsequence

  chk_load_tmr3: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TAW3) |=> acc_reg == $past(tmr_ctl_three))
    else $error("acc not loaded from timer control three");
  chk_load_tmr4: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TAW4) |=> acc_reg == $past(tmr_ctl_four))
    else $error("acc not loaded from timer control four");
  chk_col_to_acc: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TAX) |=> acc_reg == $past(col_reg) && $stable(col_reg))
    else $error("column copy wrong");
  chk_bank_to_acc: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TAZ) |=> acc_reg == {2'b00, $past(bank_reg)})
    else $error("bank copy wrong");
  chk_row_to_acc: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TAY) |=> acc_reg == $past(row_reg))
    else $error("row copy wrong");
  chk_acc_to_work: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TBA) |=> work_reg == $past(acc_reg))
    else $error("working register copy wrong");
  chk_aux_one: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TC1A) |=> aux_reg_one == $past(acc_reg))
    else $error("aux register one copy wrong");
  chk_jump_bits: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TDA) |=> jump_addr_bits == $past(acc_reg[2:0]))
    else $error("jump address bits wrong");
  chk_ext_pair: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_EXT_PAIR) |=> ext_reg == {$past(work_reg), $past(acc_reg)})
    else $error("extension pair wrong");
  chk_outstruct_two: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TFR2) |=> port_outstruct_two == $past(acc_reg))
    else $error("output structure two copy wrong");
  chk_irq_enable: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TV1) |=> irq_enable_one == $past(acc_reg))
    else $error("interrupt enable one copy wrong");
  chk_wake_two: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TK2) |=> wake_ctl_two == $past(acc_reg))
    else $error("wakeup control two copy wrong");
  chk_disp_ctl: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TL1) |=> disp_ctl_one == $past(acc_reg))
    else $error("display control one copy wrong");
  chk_disp_timer: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TLC) |=> disp_timer_count == $past(acc_reg) &&
        disp_timer_reload == $past(acc_reg))
    else $error("display timer or reload wrong");
  chk_store_xor: assert property (
      @(posedge hclk) disable iff (!hresetn)
      exec && op[9:4] == OP_STORE_HI |=>
        col_reg == ($past(col_reg) ^ $past(op[3:0])))
    else $error("column not updated by immediate");
  chk_clk_mode: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TMR) |=> clk_mode_reg == $past(acc_reg))
    else $error("clock mode copy wrong");
  chk_port_bit: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TPA) |=> tmr_port_assign == $past(acc_reg[0]))
    else $error("port assign bit wrong");
  chk_prescale: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_PRE_PAIR) |=>
        prescale_count == {$past(work_reg), $past(acc_reg)} &&
        prescale_reload == {$past(work_reg), $past(acc_reg)})
    else $error("prescaler pair wrong");
  chk_pullup_one: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TPU1) |=> pullup_ctl_one == $past(acc_reg))
    else $error("pull-up one copy wrong");
  chk_tmr1_reload: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TR1) |=> tmr1_reload == {$past(work_reg), $past(acc_reg)})
    else $error("timer one reload wrong");
  chk_clk_source: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TRG) |=> clk_source_reg == $past(acc_reg))
    else $error("clock source copy wrong");
  chk_tmr_ctl_one: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_exec(OP_TW1) |=> tmr_ctl_one == $past(acc_reg))
    else $error("timer control one copy wrong");

endmodule // artd_core

// ---- hdl/artd_pkg.sv ----
package artd_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets (AHB-Lite, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ARTD_OFF_INSN = 8'h00;
  localparam logic [7:0] ARTD_OFF_ACC = 8'h04;
  localparam logic [7:0] ARTD_OFF_WORK = 8'h08;
  localparam logic [7:0] ARTD_OFF_PTR = 8'h0C;
  localparam logic [7:0] ARTD_OFF_TMR = 8'h10;
  localparam logic [7:0] ARTD_OFF_PORT = 8'h14;
  localparam logic [7:0] ARTD_OFF_IRQ = 8'h18;
  localparam logic [7:0] ARTD_OFF_DISP = 8'h1C;
  localparam logic [7:0] ARTD_OFF_CLK = 8'h20;
  localparam logic [7:0] ARTD_OFF_PRE = 8'h24;
  localparam logic [7:0] ARTD_OFF_RAM = 8'h28;
  localparam logic [7:0] ARTD_OFF_STAT = 8'h2C;
  localparam logic [7:0] ARTD_OFF_AUX = 8'h30;
  localparam logic [3:0] ARTD_RST_NIB = 4'h0;
  localparam int ARTD_RAM_WORDS = 16;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [9:0] OP_TAW3 = 10'h24D;
  localparam logic [9:0] OP_TAW4 = 10'h24E;
  localparam logic [9:0] OP_TAX = 10'h052;
  localparam logic [9:0] OP_TAZ = 10'h053;
  localparam logic [9:0] OP_TBA = 10'h00E;
  localparam logic [9:0] OP_TC1A = 10'h2A8;
  localparam logic [9:0] OP_TC2A = 10'h2A9;
  localparam logic [9:0] OP_TDA = 10'h029;
  localparam logic [9:0] OP_EXT_PAIR = 10'h01A;
  localparam logic [9:0] OP_TFR0 = 10'h228;
  localparam logic [9:0] OP_TFR1 = 10'h229;
  localparam logic [9:0] OP_TFR2 = 10'h22A;
  localparam logic [9:0] OP_TI1 = 10'h217;
  localparam logic [9:0] OP_TV1 = 10'h03F;
  localparam logic [9:0] OP_TV2 = 10'h03E;
  localparam logic [9:0] OP_TK0 = 10'h21B;
  localparam logic [9:0] OP_TK1 = 10'h214;
  localparam logic [9:0] OP_TK2 = 10'h215;
  localparam logic [9:0] OP_TL1 = 10'h20A;
  localparam logic [9:0] OP_TL2 = 10'h20B;
  localparam logic [9:0] OP_TL3 = 10'h20C;
  localparam logic [9:0] OP_TLC = 10'h20D;
  localparam logic [5:0] OP_STORE_HI = 6'h2B;
  localparam logic [9:0] OP_TMR = 10'h216;
  localparam logic [9:0] OP_TPA = 10'h2AA;
  localparam logic [9:0] OP_PRE_PAIR = 10'h235;
  localparam logic [9:0] OP_TPU0 = 10'h22D;
  localparam logic [9:0] OP_TPU1 = 10'h22E;
  localparam logic [9:0] OP_TR1 = 10'h23F;
  localparam logic [9:0] OP_TRG = 10'h209;
  localparam logic [9:0] OP_TW1 = 10'h20E;
  localparam logic [9:0] OP_TW2 = 10'h20F;
  localparam logic [9:0] OP_TAY = 10'h01F;
endpackage

// ---- dv/artd_ahb_master.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Bus master model
// ---------------------------------------------------------------
module artd_ahb_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Single word transfer; a stall past the bound is reported
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic to);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 64) begin
      n++;
      @(posedge hclk);
    end
    htrans <= 2'h0;
    // Reads toggle the data lines so stale data never looks valid
    hwdata <= w ? d : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 64) begin
      n++;
      @(posedge hclk);
    end
    q = hrdata;
    to = (n >= 64);
  endtask
endmodule // artd_ahb_master

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Testbench
// ---------------------------------------------------------------
module tb_top;
  import artd_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, carry_flag, skip_next;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] w [0:12];
  logic [3:0] ram [0:15];
  bit kn [0:15];
  int n_fail = 0;
  int tests_run = 0;
  localparam logic [9:0] OPS [0:32] = '{OP_TAW3, OP_TAW4, OP_TAX,
    OP_TAZ, OP_TBA, OP_TC1A, OP_TC2A, OP_TDA, OP_EXT_PAIR, OP_TFR0, OP_TFR1,
    OP_TFR2, OP_TI1, OP_TV1, OP_TV2, OP_TK0, OP_TK1, OP_TK2, OP_TL1,
    OP_TL2, OP_TL3, OP_TLC, OP_TMR, OP_TPA, OP_PRE_PAIR, OP_TPU0, OP_TPU1,
    OP_TR1, OP_TRG, OP_TW1, OP_TW2, OP_TAY, {OP_STORE_HI, 4'h5}};

  // Clock at 250 MHz
  always #2 hclk = ~hclk;

  artd_ahb_master m_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  artd_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .carry_flag(carry_flag),
    .skip_next(skip_next));

  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string m);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t %s seen %h exp %h", $time, m, s, e);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Bus access; every access, read or write, also watches the fixed status outputs
  task automatic bus(input logic [7:0] a, input logic wr,
                     input logic [31:0] d, output logic [31:0] q);
    logic to;
    m_u.xfer({24'h0, a}, wr, d, q, to);
    chk({29'h0, hresp, carry_flag, skip_next}, 32'h0, "status");
    if (to) begin
      n_fail++;
      give_verdict();
    end
  endtask

  // Reference model of one instruction, acc taken before the update
  task automatic model(input logic [9:0] op);
    logic [3:0] a, b;
    a = w[1][3:0];
    b = w[2][3:0];
    if (op[9:4] == OP_STORE_HI) begin
      ram[w[3][3:0]] = a;
      kn[w[3][3:0]] = 1'b1;
      w[3][3:0] = w[3][3:0] ^ op[3:0];
    end
    case (op)
      OP_TAW3: w[1][3:0] = w[4][11:8];
      OP_TAW4: w[1][3:0] = w[4][15:12];
      OP_TAX: w[1][3:0] = w[3][3:0];
      OP_TAZ: w[1][3:0] = {2'b00, w[3][9:8]};
      OP_TAY: w[1][3:0] = w[3][7:4];
      OP_TBA: w[2][3:0] = a;
      OP_TC1A: w[12][3:0] = a;
      OP_TC2A: w[12][7:4] = a;
      OP_TDA: w[12][10:8] = a[2:0];
      OP_EXT_PAIR: w[9][7:0] = {b, a};
      OP_TFR0: w[5][3:0] = a;
      OP_TFR1: w[5][7:4] = a;
      OP_TFR2: w[5][11:8] = a;
      OP_TPU0: w[5][15:12] = a;
      OP_TPU1: w[5][19:16] = a;
      OP_TI1: w[6][3:0] = a;
      OP_TV1: w[6][7:4] = a;
      OP_TV2: w[6][11:8] = a;
      OP_TK0: w[6][15:12] = a;
      OP_TK1: w[6][19:16] = a;
      OP_TK2: w[6][23:20] = a;
      OP_TL1: w[7][3:0] = a;
      OP_TL2: w[7][7:4] = a;
      OP_TL3: w[7][11:8] = a;
      OP_TLC: w[7][19:12] = {a, a};
      OP_TMR: w[8][3:0] = a;
      OP_TRG: w[8][7:4] = a;
      OP_TPA: w[8][8] = a[0];
      OP_PRE_PAIR: w[9][31:16] = {b, a, b, a};
      OP_TR1: w[9][15:8] = {b, a};
      OP_TW1: w[4][3:0] = a;
      OP_TW2: w[4][7:4] = a;
      default: ;
    endcase
  endtask

  task automatic exec(input logic [9:0] op);
    logic [31:0] q;
    model(op);
    w[11] = w[11] + 32'h1;
    bus(ARTD_OFF_INSN, 1'b1, {22'h0, op}, q);
  endtask

  // Register writes keep only the implemented bits
  task automatic put(input int i, input logic [31:0] d);
    logic [31:0] q;
    logic [31:0] m;
    m = (i == 3) ? 32'h3FF : ((i == 4) ? 32'hFF00 : 32'hF);
    w[i] = (w[i] & ~m) | (d & m);
    bus(8'(i * 4), 1'b1, d, q);
  endtask

  // Read back every mapped word and one unmapped place
  task automatic check_all;
    logic [31:0] q;
    for (int i = 1; i <= 12; i++) begin
      bus(8'(i * 4), 1'b0, 32'h0, q);
      if (i != 10) begin
        chk(q, w[i], "reg");
      end else if (kn[w[3][3:0]]) begin
        chk(q, {28'h0, ram[w[3][3:0]]}, "ram");
      end
    end
    bus(8'h40, 1'b0, 32'h0, q);
    chk(q, 32'h0, "unmapped");
  endtask

  task automatic clear;
    for (int i = 0; i <= 12; i++) w[i] = 32'h0;
    // RAM resets to zero, so every word is known from the start
    for (int i = 0; i < 16; i++) begin
      ram[i] = 4'h0;
      kn[i] = 1'b1;
    end
  endtask

  // Hang guard
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  // Main sequence
  initial begin
    logic [9:0] op;
    logic [31:0] q;
    clear();
    void'($urandom(32'h09a6));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_all();
    // Every instruction once, random operands
    for (int k = 0; k < 33; k++) begin
      put(1, $urandom());
      put(4, $urandom());
      put(2, $urandom());
      put(3, $urandom());
      exec(OPS[k]);
      check_all();
    end
    // All-ones operands, back to back, masked bits ignored
    put(1, 32'hF);
    put(2, 32'hF);
    put(3, 32'h3FF);
    exec(OP_TDA);
    exec(OP_TPA);
    exec(OP_EXT_PAIR);
    exec(OP_TAZ);
    exec(OP_TBA);
    exec(10'h3FF);
    check_all();
    // Store with every immediate, then walk the column
    for (int j = 0; j < 16; j++) begin
      put(1, $urandom());
      exec({OP_STORE_HI, 4'(j)});
    end
    for (int c = 0; c < 16; c++) begin
      put(3, 32'(c));
      check_all();
    end
    // Random mix
    repeat (300) begin
      case ($urandom_range(0, 4))
        0: put(1, $urandom());
        1: put(2, $urandom());
        2: put(3, $urandom());
        3: put(4, $urandom());
        default: begin
          op = OPS[$urandom_range(0, 32)];
          if (op[9:4] == OP_STORE_HI) op[3:0] = 4'($urandom());
          exec(op);
        end
      endcase
      if ($urandom_range(0, 7) == 0) check_all();
    end
    check_all();
    // Reset again mid-run: all state back to zero
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    clear();
    check_all();
    give_verdict();
  end
endmodule // tb_top
